// ---- verilog/rdf_defs.svh ----
// Purpose: bit positions, register offsets, reset values and codes for the descriptor decoder
// Assumes: included by its bare name, definitions only
// Notes:   offsets are byte addresses on a 32-bit apb bus
`ifndef RDF_DEFS_SVH
`define RDF_DEFS_SVH

// descriptor upper fields
`define RDF_CPL_ID_HI       119
`define RDF_CPL_ID_LO       104
`define RDF_RID_EN_BIT      120
`define RDF_TC_HI           123
`define RDF_TC_LO           121
`define RDF_ATTR_NS_BIT     124
`define RDF_ATTR_RO_BIT     125
`define RDF_ATTR_IDO_BIT    126
`define RDF_FORCE_ECRC_BIT  127
`define RDF_REQ_BUS_HI      95
`define RDF_REQ_BUS_LO      88
`define RDF_REQ_DEV_HI      87
`define RDF_REQ_DEV_LO      83
`define RDF_REQ_FN_HI       87
`define RDF_REQ_FN_LO       80
`define RDF_REQ_LFN_HI      82
`define RDF_REQ_TYPE_HI     78
`define RDF_REQ_TYPE_LO     75

// message-specific fields
`define RDF_MSG_CODE_HI     111
`define RDF_MSG_CODE_LO     104
`define RDF_MSG_ROUTE_HI    114
`define RDF_MSG_ROUTE_LO    112
`define RDF_SNOOP_LAT_HI    15
`define RDF_SNOOP_LAT_LO    0
`define RDF_NSNOOP_LAT_HI   31
`define RDF_NSNOOP_LAT_LO   16
`define RDF_OBFF_HI         35
`define RDF_OBFF_LO         32
`define RDF_DEST_ID_HI      15
`define RDF_DEST_ID_LO      0
`define RDF_VDM_HDR_HI      63
`define RDF_VDM_HDR_LO      32

// request type codes that select a message
`define RDF_RT_MSG          4'hc
`define RDF_RT_MSG_VDM      4'hd
`define RDF_RT_MSG_ATS      4'he
// message codes recognised inside a generic message, and the id routing code of a vendor message
`define RDF_MC_LTR          8'h10
`define RDF_MC_OBFF         8'h12
`define RDF_ROUTE_BY_ID     3'h2

// register offsets
`define RDF_REG_CTRL        12'h000
`define RDF_REG_CAPID       12'h004
`define RDF_REG_STATUS      12'h008
`define RDF_REG_LASTID      12'h00c
// ctrl fields
`define RDF_CTRL_EP_BIT     0
`define RDF_CTRL_ARI_BIT    1
`define RDF_CTRL_NS_BIT     2
`define RDF_CTRL_RO_BIT     3
`define RDF_CTRL_IDO_BIT    4
`define RDF_CTRL_ECRC_BIT   5
`define RDF_CTRL_W          6
`define RDF_CTRL_RST        6'h01
// capid fields
`define RDF_CAP_BUS_HI      15
`define RDF_CAP_BUS_LO      8
`define RDF_CAP_DEV_HI      7
`define RDF_CAP_DEV_LO      3

`endif

// ---- verilog/rdf_pkg.sv ----
// Purpose: types of the request descriptor upper field decoder
// Assumes: constants live in rdf_defs.svh
// Notes:   one struct holds every flip-flop of the top module
`default_nettype none
package rdf_pkg;

	typedef enum logic [1:0] {
		RDF_ST_IDLE = 2'b01,
		RDF_ST_HOLD = 2'b10
	} rdf_state_t;

	typedef struct packed {
		rdf_state_t  state;
		logic        desc_ready;
		logic        hdr_valid;
		logic [2:0]  tc;
		logic [2:0]  attr;
		logic        digest;
		logic [15:0] req_id;
		logic [15:0] cpl_id;
		logic [7:0]  cpl_bus;
		logic [4:0]  cpl_dev;
		logic [7:0]  cpl_func;
		logic        is_msg;
		logic [7:0]  msg_code;
		logic [2:0]  msg_route;
		logic [31:0] dw2;
		logic [31:0] dw3;
		logic [5:0]  ctrl;
		logic [7:0]  cap_bus;
		logic [4:0]  cap_dev;
		logic [15:0] hdr_count;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} rdf_regs_t;

endpackage
`default_nettype wire

// ---- verilog/rdf_id_map.sv ----
// Purpose: completer id split and requester id selection
// Assumes: purely combinational, results registered by the caller
// Notes:   ari mode has no device number in either id
`default_nettype none
`include "rdf_defs.svh"
module rdf_id_map (
	input  wire logic [127:0] desc,
	input  wire logic         endpoint_mode,
	input  wire logic         ari_mode,
	input  wire logic [7:0]   cap_bus,
	input  wire logic [4:0]   cap_dev,
	output logic      [7:0]   cpl_bus,
	output logic      [4:0]   cpl_dev,
	output logic      [7:0]   cpl_func,
	output logic      [15:0]  req_id
);
	logic [15:0] cid;
	logic        use_desc;
	logic [7:0]  rbus;
	logic [4:0]  rdev;

	assign cid = desc[`RDF_CPL_ID_HI:`RDF_CPL_ID_LO];

	// ari: bus then 8-bit function; legacy: bus, device, function
	always_comb begin
		cpl_bus = cid[15:8];
		if (ari_mode) begin // see RL2
			cpl_dev  = 5'h00;
			cpl_func = cid[7:0];
		end else begin
			cpl_dev  = cid[7:3];
			cpl_func = {5'h00, cid[2:0]};
		end
	end

	// override only counts for an endpoint; a root complex always supplies its own
	assign use_desc = !endpoint_mode || desc[`RDF_RID_EN_BIT]; // see RL3 see RL4
	assign rbus = use_desc ? desc[`RDF_REQ_BUS_HI:`RDF_REQ_BUS_LO] : cap_bus;
	assign rdev = use_desc ? desc[`RDF_REQ_DEV_HI:`RDF_REQ_DEV_LO] : cap_dev;

	always_comb begin
		if (ari_mode) begin
			req_id = {rbus, desc[`RDF_REQ_FN_HI:`RDF_REQ_FN_LO]};
		end else begin
			req_id = {rbus, rdev, desc[`RDF_REQ_LFN_HI:`RDF_REQ_FN_LO]};
		end
	end
endmodule
`default_nettype wire

// ---- verilog/rdf_desc_upper.sv ----
// Purpose: decode upper and message fields of a requester descriptor into header fields
// Assumes: one descriptor per desc_valid/desc_ready handshake, apb register access
// Notes:   one header is held at a time until hdr_ready takes it
//
// Contract
// RL1 - requester puts completer id in bits 119:104, legacy bus/device/function
// RL2 - with ari active completer id is bus plus 8-bit function
// RL3 - bit 120 clear uses captured bus/device, set uses descriptor values
// RL4 - requester id override applies to endpoints only, not root complex
// RL5 - traffic class from bits 123:121 into the header
// RL6 - attributes from 126:124: no-snoop, relaxed ordering, id-based ordering
// RL7 - requester sets id-based ordering only on memory requests and messages
// RL8 - attribute bit cleared when not enabled in device control
// RL9 - bit 127 forces an ecrc digest even with ecrc disabled
// RL10 - ltr message: bits 15:0 become the snoop latency field
// RL11 - ltr message: bits 31:16 become the no-snoop latency field
// RL12 - requester encodes obff code 1111b, 0001b or 0000b only
// RL13 - every message takes its message code from bits 111:104
// RL14 - every message copies routing bits 114:112 unchanged
// RL15 - id-routed vendor message carries destination id in bits 15:0
// RL16 - vendor message copies bits 63:32 into header doubleword 3
// RL17 - ats message copies bits 63:0 into header doublewords 2 and 3
// RL18 - every request starts with a 16-byte descriptor, payload after
// RL19 - requester supplies bus number in 95:88 when override or root complex
// RL20 - request type in bits 78:75 selects message field interpretation
// RL21 - message fields ignored for non-message types, header unaffected
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`default_nettype none
`include "rdf_defs.svh"
module rdf_desc_upper #(
	parameter int ADDR_W = 12
) (
	input  wire logic              core_clk,
	input  wire logic              rstn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [31:0]       prdata,
	// descriptor in
	input  wire logic              desc_valid,
	input  wire logic [127:0]      desc_data,
	output logic                   desc_ready,
	// header out
	input  wire logic              hdr_ready,
	output logic                   hdr_valid,
	output logic      [2:0]        hdr_traffic_class_field,
	output logic      [2:0]        hdr_attr,
	output logic                   hdr_digest,
	output logic      [15:0]       hdr_requester_id,
	output logic      [15:0]       hdr_completer_id,
	output logic      [7:0]        hdr_cpl_bus,
	output logic      [4:0]        hdr_cpl_dev,
	output logic      [7:0]        hdr_cpl_func,
	output logic                   hdr_is_msg,
	output logic      [7:0]        hdr_msg_code,
	output logic      [2:0]        hdr_msg_route,
	output logic      [31:0]       hdr_dw2,
	output logic      [31:0]       hdr_dw3
);
	////////////////////////////////////////////////////////////////////////////
	// state and field extraction
	rdf_pkg::rdf_regs_t r;
	rdf_pkg::rdf_regs_t n;

	logic [7:0]  map_cpl_bus;
	logic [4:0]  map_cpl_dev;
	logic [7:0]  map_cpl_func;
	logic [15:0] map_req_id;
	logic [3:0]  req_type;
	logic        is_msg;
	logic [7:0]  msg_code;
	logic [2:0]  msg_route;
	logic [2:0]  attr_in;
	logic [2:0]  attr_en;
	logic        take_desc;
	logic        apb_acc;
	logic [31:0] ctrl_word;
	logic [31:0] capid_word;
	logic [31:0] status_word;
	logic [31:0] lastid_word;

	assign req_type = desc_data[`RDF_REQ_TYPE_HI:`RDF_REQ_TYPE_LO];
	assign is_msg   = (req_type == `RDF_RT_MSG) || (req_type == `RDF_RT_MSG_VDM)
		|| (req_type == `RDF_RT_MSG_ATS); // see RL20
	assign msg_code  = desc_data[`RDF_MSG_CODE_HI:`RDF_MSG_CODE_LO];
	assign msg_route = desc_data[`RDF_MSG_ROUTE_HI:`RDF_MSG_ROUTE_LO];

	assign attr_in = {desc_data[`RDF_ATTR_IDO_BIT], desc_data[`RDF_ATTR_RO_BIT],
		desc_data[`RDF_ATTR_NS_BIT]}; // see RL6
	assign attr_en = {r.ctrl[`RDF_CTRL_IDO_BIT], r.ctrl[`RDF_CTRL_RO_BIT],
		r.ctrl[`RDF_CTRL_NS_BIT]};

	assign take_desc = desc_valid && r.desc_ready;
	// one wait state: answer lands on the cycle after the first access cycle
	assign apb_acc   = psel && penable && !r.pready;

	rdf_id_map u_id_map (
		.desc          (desc_data),
		.endpoint_mode (r.ctrl[`RDF_CTRL_EP_BIT]),
		.ari_mode      (r.ctrl[`RDF_CTRL_ARI_BIT]),
		.cap_bus       (r.cap_bus),
		.cap_dev       (r.cap_dev),
		.cpl_bus       (map_cpl_bus),
		.cpl_dev       (map_cpl_dev),
		.cpl_func      (map_cpl_func),
		.req_id        (map_req_id)
	);

	////////////////////////////////////////////////////////////////////////////
	// register read views
	always_comb begin
		ctrl_word  = 32'h0000_0000;
		ctrl_word[`RDF_CTRL_W-1:0] = r.ctrl;
		capid_word = 32'h0000_0000;
		capid_word[`RDF_CAP_BUS_HI:`RDF_CAP_BUS_LO] = r.cap_bus;
		capid_word[`RDF_CAP_DEV_HI:`RDF_CAP_DEV_LO] = r.cap_dev;
		status_word = {r.hdr_count, 14'h0000, r.desc_ready, r.hdr_valid};
		lastid_word = {r.req_id, r.cpl_id};
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		n = r;
		n.pready  = 1'b0;
		n.pslverr = 1'b0;

		// apb slave: ctrl and capid writes honour byte strobes, a status write clears regardless, unmapped answers with pslverr
		if (apb_acc) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			if (paddr == `RDF_REG_CTRL) begin
				if (pwrite) begin
					if (pstrb[0]) begin
						n.ctrl = pwdata[`RDF_CTRL_W-1:0];
					end
				end else begin
					n.prdata = ctrl_word;
				end
			end else if (paddr == `RDF_REG_CAPID) begin
				if (pwrite) begin
					if (pstrb[1]) begin
						n.cap_bus = pwdata[`RDF_CAP_BUS_HI:`RDF_CAP_BUS_LO];
					end
					if (pstrb[0]) begin
						n.cap_dev = pwdata[`RDF_CAP_DEV_HI:`RDF_CAP_DEV_LO];
					end
				end else begin
					n.prdata = capid_word;
				end
			end else if (paddr == `RDF_REG_STATUS) begin
				// writing clears the header counter; a descriptor taken now still counts
				if (pwrite) begin
					n.hdr_count = 16'h0000;
				end else begin
					n.prdata = status_word;
				end
			end else if (paddr == `RDF_REG_LASTID) begin
				if (!pwrite) begin
					n.prdata = lastid_word;
				end
			end else begin
				n.pslverr = 1'b1;
			end
		end

		case (r.state)
			rdf_pkg::RDF_ST_IDLE: begin
				if (take_desc) begin
					n.state      = rdf_pkg::RDF_ST_HOLD;
					n.desc_ready = 1'b0;
					n.hdr_valid  = 1'b1;
					// builds on a clear from the same cycle, so a take beats the clear
					n.hdr_count  = n.hdr_count + 16'h0001;
					n.tc         = desc_data[`RDF_TC_HI:`RDF_TC_LO]; // see RL5
					n.attr       = attr_in & attr_en; // see RL8
					// forced digest wins over a disabled ecrc setting
					n.digest     = desc_data[`RDF_FORCE_ECRC_BIT]
						|| r.ctrl[`RDF_CTRL_ECRC_BIT]; // see RL9
					n.req_id     = map_req_id; // see RL3 see RL4 see RL19
					n.cpl_id     = desc_data[`RDF_CPL_ID_HI:`RDF_CPL_ID_LO]; // see RL1
					n.cpl_bus    = map_cpl_bus;
					n.cpl_dev    = map_cpl_dev; // see RL2
					n.cpl_func   = map_cpl_func;
					n.is_msg     = is_msg;
					// non-message types leave all message fields at zero
					n.msg_code   = 8'h00; // see RL21
					n.msg_route  = 3'h0;
					n.dw2        = 32'h0000_0000;
					n.dw3        = 32'h0000_0000;
					if (is_msg) begin
						n.msg_code  = msg_code; // see RL13
						n.msg_route = msg_route; // see RL14
						if (req_type == `RDF_RT_MSG_ATS) begin
							n.dw2 = desc_data[31:0]; // see RL17
							n.dw3 = desc_data[63:32];
						end else if (req_type == `RDF_RT_MSG_VDM) begin
							// destination id only meaningful for id routing
							if (msg_route == `RDF_ROUTE_BY_ID) begin // see RL15
								n.dw2[15:0] = desc_data[`RDF_DEST_ID_HI:`RDF_DEST_ID_LO];
							end
							n.dw3 = desc_data[`RDF_VDM_HDR_HI:`RDF_VDM_HDR_LO]; // see RL16
						end else if (msg_code == `RDF_MC_LTR) begin
							n.dw3[31:16] = desc_data[`RDF_NSNOOP_LAT_HI:`RDF_NSNOOP_LAT_LO]; // see RL11
							n.dw3[15:0]  = desc_data[`RDF_SNOOP_LAT_HI:`RDF_SNOOP_LAT_LO]; // see RL10
						end else if (msg_code == `RDF_MC_OBFF) begin
							// reserved codes are passed through; the user must not send them
							n.dw3[3:0] = desc_data[`RDF_OBFF_HI:`RDF_OBFF_LO]; // see RL12
						end
					end
				end
			end
			rdf_pkg::RDF_ST_HOLD: begin
				// header stands until taken; next descriptor one cycle later
				if (hdr_ready) begin
					n.state      = rdf_pkg::RDF_ST_IDLE;
					n.hdr_valid  = 1'b0;
					n.desc_ready = 1'b1;
				end
			end
			default: begin
				n.state      = rdf_pkg::RDF_ST_IDLE;
				n.hdr_valid  = 1'b0;
				n.desc_ready = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			r            <= '0;
			r.state      <= rdf_pkg::RDF_ST_IDLE;
			r.desc_ready <= 1'b1;
			r.ctrl       <= `RDF_CTRL_RST;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign pready                  = r.pready;
	assign pslverr                 = r.pslverr;
	assign prdata                  = r.prdata;
	assign desc_ready              = r.desc_ready;
	assign hdr_valid               = r.hdr_valid;
	assign hdr_traffic_class_field = r.tc;
	assign hdr_attr                = r.attr;
	assign hdr_digest              = r.digest;
	assign hdr_requester_id        = r.req_id;
	assign hdr_completer_id        = r.cpl_id;
	assign hdr_cpl_bus             = r.cpl_bus;
	assign hdr_cpl_dev             = r.cpl_dev;
	assign hdr_cpl_func            = r.cpl_func;
	assign hdr_is_msg              = r.is_msg;
	assign hdr_msg_code            = r.msg_code;
	assign hdr_msg_route           = r.msg_route;
	assign hdr_dw2                 = r.dw2;
	assign hdr_dw3                 = r.dw3;
endmodule
`default_nettype wire

// ---- test/rdf_desc_upper_asserts.sv ----
// Purpose: concurrent checks on the descriptor decoder ports
// Assumes: one clock domain, rstn asynchronous active low
// Notes:   control register contents are invisible here, so masks are checked as subsets
`default_nettype none
`include "rdf_defs.svh"
module rdf_desc_upper_asserts (
	input wire logic         core_clk,
	input wire logic         rstn,
	input wire logic         desc_valid,
	input wire logic [127:0] desc_data,
	input wire logic         desc_ready,
	input wire logic         hdr_ready,
	input wire logic         hdr_valid,
	input wire logic [2:0]   hdr_traffic_class_field,
	input wire logic [2:0]   hdr_attr,
	input wire logic         hdr_digest,
	input wire logic [15:0]  hdr_requester_id,
	input wire logic [15:0]  hdr_completer_id,
	input wire logic [7:0]   hdr_cpl_bus,
	input wire logic [7:0]   hdr_cpl_func,
	input wire logic         hdr_is_msg,
	input wire logic [7:0]   hdr_msg_code,
	input wire logic [2:0]   hdr_msg_route,
	input wire logic [31:0]  hdr_dw2,
	input wire logic [31:0]  hdr_dw3,
	input wire logic         pready,
	input wire logic         pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       tk;
	logic       msg;
	logic [3:0] rt;
	assign tk = desc_valid && desc_ready;
	assign rt = desc_data[78:75];
	assign msg = rt inside {`RDF_RT_MSG, `RDF_RT_MSG_VDM, `RDF_RT_MSG_ATS};
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
////////////////////////////////////////////////////////////////////////////////
	a_tc_copy: assert property (tk |=> hdr_valid && !desc_ready &&
		hdr_traffic_class_field == $past(desc_data[123:121])) else $error("tc not copied");
	a_attr_mask: assert property (tk |=>
		(hdr_attr & ~$past(desc_data[126:124])) == 3'h0) else $error("attr set without cause");
	a_digest_force: assert property (tk && desc_data[127] |=> hdr_digest)
		else $error("forced digest missing");
	a_cpl_split: assert property (tk |=> hdr_completer_id == $past(desc_data[119:104])
		&& hdr_cpl_bus == hdr_completer_id[15:8] && hdr_cpl_func[2:0] == hdr_completer_id[2:0])
		else $error("completer split wrong");
	a_msg_fields: assert property (tk && msg |=> hdr_is_msg &&
		hdr_msg_code == $past(desc_data[111:104]) && hdr_msg_route == $past(desc_data[114:112]))
		else $error("message code or route wrong");
	a_nonmsg_zero: assert property (tk && !msg |=> !hdr_is_msg && hdr_msg_code == 8'h00 &&
		hdr_msg_route == 3'h0 && hdr_dw2 == 32'h0 && hdr_dw3 == 32'h0) else $error("non-message dirty");
	a_ats_copy: assert property (tk && rt == `RDF_RT_MSG_ATS |=>
		{hdr_dw3, hdr_dw2} == $past(desc_data[63:0])) else $error("ats words wrong");
	a_vdm_copy: assert property (tk && rt == `RDF_RT_MSG_VDM |=>
		hdr_dw3 == $past(desc_data[63:32])) else $error("vendor word wrong");
	a_ltr_copy: assert property (tk && rt == `RDF_RT_MSG
		&& desc_data[111:104] == `RDF_MC_LTR |=> hdr_dw3 == $past(desc_data[31:0]))
		else $error("latency fields wrong");
	a_hdr_hold: assert property (hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_dw3)
		&& $stable(hdr_requester_id)) else $error("header dropped before taken");
	c_msg: cover property (tk && msg);
	c_stall: cover property (hdr_valid && !hdr_ready);
	c_err: cover property (pready && pslverr);
endmodule
bind rdf_desc_upper rdf_desc_upper_asserts u_asserts (.core_clk, .rstn, .desc_valid, .desc_data,
	.desc_ready, .hdr_ready, .hdr_valid, .hdr_traffic_class_field, .hdr_attr, .hdr_digest,
	.hdr_requester_id, .hdr_completer_id, .hdr_cpl_bus, .hdr_cpl_func, .hdr_is_msg,
	.hdr_msg_code, .hdr_msg_route, .hdr_dw2, .hdr_dw3, .pready, .pslverr);
`default_nettype wire

// ---- test/rdf_user_model.sv ----
// Purpose: user logic offering descriptors and taking headers
// Assumes: go pulses one cycle with gdesc valid
// Notes:   data is inverted once taken so stale bits never look valid
`default_nettype none
module rdf_user_model (
	input wire logic          core_clk,
	input wire logic          rstn,
	input wire logic          go,
	input wire logic [127:0]  gdesc,
	input wire logic          stall,
	input wire logic          desc_ready,
	output var logic          desc_valid,
	output var logic [127:0]  desc_data,
	output var logic          hdr_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			desc_valid <= 1'b0;
			desc_data <= '0;
			hdr_ready <= 1'b0;
		end else begin
			hdr_ready <= !stall;
			if (go) begin
				desc_valid <= 1'b1;
				desc_data <= gdesc;
			end else if (desc_valid && desc_ready) begin
				desc_valid <= 1'b0;
				desc_data <= ~desc_data;
			end
		end
	end
endmodule
`default_nettype wire

// ---- test/rdf_desc_upper_tb.sv ----
// Purpose: scoreboard bench for the descriptor decoder
// Assumes: apb answers after one wait state, partner model on the stream side
// Notes:   expected headers are queued at send time and popped when consumed
`default_nettype none
`include "rdf_defs.svh"
`define RDF_CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module rdf_desc_upper_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rstn, psel, penable, pwrite, go, stall, pready, pslverr;
	logic desc_valid, desc_ready, hdr_ready, hdr_valid, hdr_is_msg, hdr_digest;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, dw2, dw3;
	logic [3:0]   pstrb;
	logic [127:0] desc_data, gdesc, d;
	logic [2:0]   tcf, attr, route;
	logic [15:0]  rid, cid;
	logic [7:0]   cbus, cfunc, code;
	logic [4:0]   cdev;
	logic [135:0] expq[$], e, last_e, got;
	logic [5:0]   ctrl_v;
	logic [7:0]   bus_v;
	logic [4:0]   dev_v;
	logic [5:0]   ctab[6] = '{6'h01, 6'h00, 6'h3f, 6'h03, 6'h1c, 6'h22};
	logic [3:0]   obt[3] = '{4'hf, 4'h1, 4'h0};
	int           failures, cmp_count, ntake, sel;
	integer       seed = 32'h0365_2e44;
	integer       seed_st = 32'h0365_2e44;
	rdf_desc_upper DUT (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .pslverr, .prdata, .desc_valid, .desc_data, .desc_ready, .hdr_ready, .hdr_valid,
		.hdr_traffic_class_field(tcf), .hdr_attr(attr), .hdr_digest, .hdr_requester_id(rid),
		.hdr_completer_id(cid), .hdr_cpl_bus(cbus), .hdr_cpl_dev(cdev), .hdr_cpl_func(cfunc),
		.hdr_is_msg, .hdr_msg_code(code), .hdr_msg_route(route), .hdr_dw2(dw2), .hdr_dw3(dw3));
	rdf_user_model u_user (.core_clk, .rstn, .go, .gdesc, .stall, .desc_ready, .desc_valid,
		.desc_data, .hdr_ready);
////////////////////////////////////////////////////////////////////////////////
	function automatic logic [135:0] exp_of(input logic [127:0] x);
		logic        ud, m;
		logic [7:0]  b, co;
		logic [15:0] r, c;
		logic [31:0] x2, x3;
		ud = !ctrl_v[0] || x[120];
		b = ud ? x[95:88] : bus_v;
		r = ctrl_v[1] ? {b, x[87:80]} : {b, ud ? x[87:83] : dev_v, x[82:80]};
		c = x[119:104];
		m = x[78:75] inside {`RDF_RT_MSG, `RDF_RT_MSG_VDM, `RDF_RT_MSG_ATS};
		co = m ? x[111:104] : 8'h00;
		x2 = 32'h0;
		x3 = 32'h0;
		case (x[78:75])
			`RDF_RT_MSG: begin
				x3 = co == `RDF_MC_OBFF ? {28'h0, x[35:32]} : 32'h0;
				if (co == `RDF_MC_LTR) x3 = x[31:0];
			end
			`RDF_RT_MSG_VDM: begin
				x2 = x[114:112] == `RDF_ROUTE_BY_ID ? {16'h0, x[15:0]} : 32'h0;
				x3 = x[63:32];
			end
			`RDF_RT_MSG_ATS: {x3, x2} = x[63:0];
			default: ;
		endcase
		return {x[123:121], x[126:124] & ctrl_v[4:2], x[127] | ctrl_v[5], r, c, c[15:8],
			ctrl_v[1] ? 5'h0 : c[7:3], ctrl_v[1] ? c[7:0] : {5'h0, c[2:0]}, m, co,
			m ? x[114:112] : 3'h0, x2, x3};
	endfunction
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tmo(input int k);
		if (k >= 50) begin
			failures++;
			$display("[FAIL] wait exp done got timeout");
			final_report();
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, er,
		input logic ee);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		tmo(k);
		`RDF_CHK("pslverr", ee, pslverr)
		if (!w) `RDF_CHK("prdata", er, prdata)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic send(input logic [127:0] x);
		int k;
		last_e = exp_of(x);
		expq.push_back(last_e);
		go <= 1'b1;
		gdesc <= x;
		@(posedge core_clk);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (!(desc_valid === 1'b1 && desc_ready === 1'b1) && k < 50);
		tmo(k);
		ntake++;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) stall <= ($random(seed_st) & 3) == 0;
	always @(posedge core_clk) begin
		if (rstn === 1'b1 && hdr_valid === 1'b1 && hdr_ready === 1'b1) begin
			e = expq.pop_front();
			got = {tcf, attr, hdr_digest, rid, cid, cbus, cdev, cfunc, hdr_is_msg, code, route,
				dw2, dw3};
			`RDF_CHK("id fields", e[135:76], got[135:76])
			`RDF_CHK("msg fields", e[75:0], got[75:0])
		end
	end
	initial begin
		{rstn, psel, penable, pwrite, go, paddr, pwdata, gdesc} = '0;
		pstrb = 4'hf;
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		apb(0, `RDF_REG_CTRL, 32'h0, 32'h0000_0001, 0);
		apb(0, `RDF_REG_CAPID, 32'h0, 32'h0, 0);
		apb(0, 12'h010, 32'h0, 32'h0, 1);
		apb(1, 12'hffc, 32'hffff_ffff, 32'h0, 1);
		apb(1, `RDF_REG_LASTID, 32'hffff_ffff, 32'h0, 0);
		apb(0, `RDF_REG_LASTID, 32'h0, 32'h0, 0);
		// only the bus byte strobed: device field must keep its value
		pstrb <= 4'h2;
		apb(1, `RDF_REG_CAPID, 32'h0000_5aff, 32'h0, 0);
		pstrb <= 4'hf;
		apb(0, `RDF_REG_CAPID, 32'h0, 32'h0000_5a00, 0);
		bus_v = 8'ha5;
		dev_v = 5'h13;
		apb(1, `RDF_REG_CAPID, 32'h0000_a598, 32'h0, 0);
		apb(0, `RDF_REG_CAPID, 32'h0, 32'h0000_a598, 0);
		foreach (ctab[i]) begin
			ctrl_v = ctab[i];
			apb(1, `RDF_REG_CTRL, {26'h0, ctrl_v}, 32'h0, 0);
			apb(0, `RDF_REG_CTRL, 32'h0, {26'h0, ctrl_v}, 0);
			repeat (8) begin
				d = {$random(seed), $random(seed), $random(seed), $random(seed)};
				sel = $unsigned($random(seed)) % 7;
				case (sel)
					0: {d[78:75], d[111:104]} = {`RDF_RT_MSG, `RDF_MC_LTR};
					1: {d[78:75], d[111:104], d[35:32]} = {`RDF_RT_MSG, `RDF_MC_OBFF,
						obt[$unsigned($random(seed)) % 3]};
					2: {d[78:75], d[114:112]} = {`RDF_RT_MSG_VDM, `RDF_ROUTE_BY_ID};
					3: d[78:75] = `RDF_RT_MSG_VDM;
					4: d[78:75] = `RDF_RT_MSG_ATS;
					5: d[78:75] = `RDF_RT_MSG;
					default: {d[78:75], d[126]} = {4'($unsigned($random(seed)) % 12), 1'b0};
				endcase
				send(d);
			end
			sel = 0;
			while (expq.size() != 0 && sel < 50) begin
				@(posedge core_clk);
				sel++;
			end
			tmo(sel);
		end
		apb(0, `RDF_REG_LASTID, 32'h0, last_e[128:97], 0);
		apb(0, `RDF_REG_STATUS, 32'h0, {ntake[15:0], 16'h0002}, 0);
		apb(1, `RDF_REG_STATUS, 32'h0, 32'h0, 0);
		apb(0, `RDF_REG_STATUS, 32'h0, 32'h0000_0002, 0);
		final_report();
	end
endmodule
`default_nettype wire
